// ==== ptg_defs.svh ====
// Offsets, field positions, reset values and timing counts of the pattern generator
`ifndef PTG_DEFS_SVH
`define PTG_DEFS_SVH

// Indirect register offsets
`define PTG_OFF_CTL 8'h01
`define PTG_OFF_CFG 8'h02
`define PTG_OFF_DI 8'h03
`define PTG_OFF_LINE1 8'h04
`define PTG_OFF_LINE0 8'h05
`define PTG_OFF_BAR1 8'h06
`define PTG_OFF_BAR0 8'h07
`define PTG_OFF_ACT1 8'h08
`define PTG_OFF_ACT0 8'h09
`define PTG_OFF_TOT1 8'h0a
`define PTG_OFF_TOT0 8'h0b
`define PTG_OFF_PD1 8'h0c
`define PTG_OFF_PD0 8'h0d
`define PTG_OFF_VBP 8'h0e
`define PTG_OFF_VFP 8'h0f
`define PTG_OFF_FIX0 8'h10
`define PTG_OFF_FIX15 8'h1f
`define PTG_OFF_STATUS 8'h20

// Field positions
`define PTG_CTL_EN_BIT 0
`define PTG_CFG_FIXED_BIT 7
`define PTG_CFG_BARS_HI 5
`define PTG_CFG_BARS_LO 4
`define PTG_CFG_BLK_HI 3
`define PTG_CFG_BLK_LO 0
`define PTG_DI_VC_HI 7
`define PTG_DI_VC_LO 6
`define PTG_DI_DT_HI 5
`define PTG_DI_DT_LO 0

// Reset values
`define PTG_RST_CTL 8'h00
`define PTG_RST_CFG 8'h33
`define PTG_RST_DI 8'h24
`define PTG_RST_BYTE 8'h00

// Short packet data types
`define PTG_DT_FS 6'h00
`define PTG_DT_FE 6'h01

// Reference color bar bytes, first to last
`define PTG_BAR_C0 8'haa
`define PTG_BAR_C1 8'h33
`define PTG_BAR_C2 8'hf0
`define PTG_BAR_C3 8'h7f
`define PTG_BAR_C4 8'h55
`define PTG_BAR_C5 8'hcc
`define PTG_BAR_C6 8'h0f
`define PTG_BAR_C7 8'h80

// Timing: clock period and line period unit, both in ns
`define PTG_CLK_NS 5'h04
`define PTG_UNIT_NS 5'h0a

`endif

// ==== ptg_pkg.sv ====
// Types of the pattern generator
package ptg_pkg;

	typedef enum logic [1:0] {
		PTG_IDLE = 2'b00,
		PTG_HDR = 2'b01,
		PTG_DATA = 2'b10
	} ptg_state_t;

	typedef struct packed {
		logic [7:0] ctl;
		logic [7:0] cfg;
		logic [7:0] di;
		logic [15:0] line_len;
		logic [15:0] bar_len;
		logic [15:0] act;
		logic [15:0] tot;
		logic [15:0] pd;
		logic [7:0] vbp;
		logic [7:0] vfp;
		logic [15:0][7:0] fix;
		logic [7:0] rdata;
	} ptg_regs_t;

	typedef struct packed {
		ptg_state_t state;
		logic [4:0] ns_acc;
		logic [15:0] pd_cnt;
		logic line_pend;
		logic [15:0] line_idx;
		logic frame_on;
		logic in_active;
		logic hdr_short;
		logic [5:0] hdr_dt;
		logic [15:0] hdr_wc;
		logic [7:0] byte_r;
		logic [15:0] byte_cnt;
		logic [15:0] bar_cnt;
		logic [2:0] bar_idx;
		logic [3:0] blk_idx;
	} ptg_core_t;

endpackage

// ==== ptg_cfg_if.sv ====
// Configuration carried from the register file to the generator core, and status carried back
`timescale 1ns/1ps
interface ptg_cfg_if;
	logic enable;
	logic fixed_mode;
	logic [1:0] bars_log2;
	logic [3:0] blk_size;
	logic [1:0] vc;
	logic [5:0] dt;
	logic [15:0] line_len;
	logic [15:0] bar_len;
	logic [15:0] act;
	logic [15:0] tot;
	logic [15:0] pd;
	logic [7:0] vbp;
	logic [7:0] vfp;
	logic [15:0][7:0] fix;
	logic [7:0] status;

	modport regs (
		output enable, fixed_mode, bars_log2, blk_size, vc, dt, line_len, bar_len,
		output act, tot, pd, vbp, vfp, fix,
		input status
	);
	modport core (
		input enable, fixed_mode, bars_log2, blk_size, vc, dt, line_len, bar_len,
		input act, tot, pd, vbp, vfp, fix,
		output status
	);
endinterface

// ==== ptg_regs.sv ====
// Indirect register file of the pattern generator
`timescale 1ns/1ps
`include "ptg_defs.svh"
module ptg_regs (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [7:0] reg_rdata_out,
	ptg_cfg_if.regs cfg
);

	ptg_pkg::ptg_regs_t st_r;
	ptg_pkg::ptg_regs_t st_nxt;
	logic [7:0] fix_ofs;

	assign fix_ofs = reg_addr_in - `PTG_OFF_FIX0;

	always_comb begin
		st_nxt = st_r;
		if (reg_write_in) begin
			case (reg_addr_in)
				`PTG_OFF_CTL: st_nxt.ctl = reg_wdata_in;
				`PTG_OFF_CFG: st_nxt.cfg = reg_wdata_in;
				`PTG_OFF_DI: st_nxt.di = reg_wdata_in;
				`PTG_OFF_LINE1: st_nxt.line_len[15:8] = reg_wdata_in;
				`PTG_OFF_LINE0: st_nxt.line_len[7:0] = reg_wdata_in;
				`PTG_OFF_BAR1: st_nxt.bar_len[15:8] = reg_wdata_in;
				`PTG_OFF_BAR0: st_nxt.bar_len[7:0] = reg_wdata_in;
				`PTG_OFF_ACT1: st_nxt.act[15:8] = reg_wdata_in;
				`PTG_OFF_ACT0: st_nxt.act[7:0] = reg_wdata_in;
				`PTG_OFF_TOT1: st_nxt.tot[15:8] = reg_wdata_in;
				`PTG_OFF_TOT0: st_nxt.tot[7:0] = reg_wdata_in;
				`PTG_OFF_PD1: st_nxt.pd[15:8] = reg_wdata_in;
				`PTG_OFF_PD0: st_nxt.pd[7:0] = reg_wdata_in;
				`PTG_OFF_VBP: st_nxt.vbp = reg_wdata_in;
				`PTG_OFF_VFP: st_nxt.vfp = reg_wdata_in;
				default: begin
					if (reg_addr_in >= `PTG_OFF_FIX0 && reg_addr_in <= `PTG_OFF_FIX15) begin
						st_nxt.fix[fix_ofs[3:0]] = reg_wdata_in;
					end
				end
			endcase
		end
		if (reg_read_in) begin
			case (reg_addr_in)
				`PTG_OFF_CTL: st_nxt.rdata = st_r.ctl;
				`PTG_OFF_CFG: st_nxt.rdata = st_r.cfg;
				`PTG_OFF_DI: st_nxt.rdata = st_r.di;
				`PTG_OFF_LINE1: st_nxt.rdata = st_r.line_len[15:8];
				`PTG_OFF_LINE0: st_nxt.rdata = st_r.line_len[7:0];
				`PTG_OFF_BAR1: st_nxt.rdata = st_r.bar_len[15:8];
				`PTG_OFF_BAR0: st_nxt.rdata = st_r.bar_len[7:0];
				`PTG_OFF_ACT1: st_nxt.rdata = st_r.act[15:8];
				`PTG_OFF_ACT0: st_nxt.rdata = st_r.act[7:0];
				`PTG_OFF_TOT1: st_nxt.rdata = st_r.tot[15:8];
				`PTG_OFF_TOT0: st_nxt.rdata = st_r.tot[7:0];
				`PTG_OFF_PD1: st_nxt.rdata = st_r.pd[15:8];
				`PTG_OFF_PD0: st_nxt.rdata = st_r.pd[7:0];
				`PTG_OFF_VBP: st_nxt.rdata = st_r.vbp;
				`PTG_OFF_VFP: st_nxt.rdata = st_r.vfp;
				`PTG_OFF_STATUS: st_nxt.rdata = cfg.status;
				default: begin
					if (reg_addr_in >= `PTG_OFF_FIX0 && reg_addr_in <= `PTG_OFF_FIX15) begin
						st_nxt.rdata = st_r.fix[fix_ofs[3:0]];
					end else begin
						st_nxt.rdata = 8'h00;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_r <= '0;
			st_r.ctl <= `PTG_RST_CTL;
			st_r.cfg <= `PTG_RST_CFG;
			st_r.di <= `PTG_RST_DI;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata_out = st_r.rdata;
	assign cfg.enable = st_r.ctl[`PTG_CTL_EN_BIT];
	assign cfg.fixed_mode = st_r.cfg[`PTG_CFG_FIXED_BIT];
	assign cfg.bars_log2 = st_r.cfg[`PTG_CFG_BARS_HI:`PTG_CFG_BARS_LO];
	assign cfg.blk_size = st_r.cfg[`PTG_CFG_BLK_HI:`PTG_CFG_BLK_LO];
	assign cfg.vc = st_r.di[`PTG_DI_VC_HI:`PTG_DI_VC_LO];
	assign cfg.dt = st_r.di[`PTG_DI_DT_HI:`PTG_DI_DT_LO];
	assign cfg.line_len = st_r.line_len;
	assign cfg.bar_len = st_r.bar_len;
	assign cfg.act = st_r.act;
	assign cfg.tot = st_r.tot;
	assign cfg.pd = st_r.pd;
	assign cfg.vbp = st_r.vbp;
	assign cfg.vfp = st_r.vfp;

	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_fix
			assign cfg.fix[gi] = st_r.fix[gi];
		end
	endgenerate

endmodule

// ==== ptg_top.sv ====
// CSI-2 test pattern generator: register file, line timing and packet stream
`timescale 1ns/1ps
`include "ptg_defs.svh"
// Notes on behaviour
// - Color bar or fixed color pattern selectable
// - Default eight bars in fixed byte order
// - Last bar stretches to fill line
// - One, two, four or eight bars
// - Line and bar lengths in bytes
// - Programmed data type in long packets, programmed channel in all packets
// - Active and total lines per frame
// - Line starts paced in 10 ns units
// - Front porch blank lines before frame end
// - Back porch blank lines after frame start
// - Formatted packets straight to transmitter
// - Fixed mode shares all dimension settings
// - Fixed bars alternate data and inverse
// - Fixed block up to sixteen bytes
// - Sixteen programmable block byte registers
module ptg_top (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [7:0] reg_rdata_out,
	output logic hdr_valid_out,
	input wire logic hdr_ready_in,
	output logic hdr_short_out,
	output logic [5:0] hdr_dt_out,
	output logic [1:0] hdr_vc_out,
	output logic [15:0] hdr_wc_out,
	output logic data_valid_out,
	input wire logic data_ready_in,
	output logic [7:0] data_byte_out,
	output logic data_last_out
);

	////////////////////////////////////////////////////////////////////////////////
	// Reset release
	logic rst_meta_r;
	logic rst_sync_r;

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	ptg_cfg_if cfg ();

	ptg_regs u_regs (
		.clock_in(clock_in),
		.rst_n_in(rst_sync_r),
		.reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in),
		.reg_write_in(reg_write_in),
		.reg_read_in(reg_read_in),
		.reg_rdata_out(reg_rdata_out),
		.cfg(cfg.regs)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Pattern byte lookup
	function automatic logic [7:0] ptg_pattern(input logic fixed, input logic [2:0] bar,
		input logic [3:0] blk, input logic [15:0][7:0] fix);
		logic [7:0] v;
		v = 8'h00;
		if (fixed) begin
			v = fix[blk] ^ {8{bar[0]}};
		end else begin
			case (bar)
				3'h0: v = `PTG_BAR_C0;
				3'h1: v = `PTG_BAR_C1;
				3'h2: v = `PTG_BAR_C2;
				3'h3: v = `PTG_BAR_C3;
				3'h4: v = `PTG_BAR_C4;
				3'h5: v = `PTG_BAR_C5;
				3'h6: v = `PTG_BAR_C6;
				default: v = `PTG_BAR_C7;
			endcase
		end
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Core state
	ptg_pkg::ptg_core_t st_r;
	ptg_pkg::ptg_core_t st_nxt;

	logic [2:0] last_bar;
	logic [3:0] last_blk;
	logic [16:0] first_act;
	logic [16:0] last_act;
	logic [16:0] fe_line;
	logic [16:0] idx_w;
	logic [15:0] pd_end;
	logic [4:0] acc_sum;
	logic tick_10ns;
	logic line_go;
	logic is_start;
	logic is_active;
	logic is_end;
	logic is_wrap;
	logic hdr_go;
	logic hdr_short_sel;
	logic [5:0] hdr_dt_sel;
	logic [15:0] hdr_wc_sel;
	logic last_take;
	logic bar_step;
	logic [2:0] bar_idx_nxt;
	logic [15:0] bar_cnt_nxt;
	logic [3:0] blk_idx_nxt;

	always_comb begin
		case (cfg.bars_log2)
			2'h0: last_bar = 3'h0;
			2'h1: last_bar = 3'h1;
			2'h2: last_bar = 3'h3;
			default: last_bar = 3'h7;
		endcase
	end

	assign last_blk = (cfg.blk_size == 4'h0) ? 4'hf : cfg.blk_size - 4'h1;
	assign first_act = {9'h000, cfg.vbp} + 17'h00001;
	assign last_act = {9'h000, cfg.vbp} + {1'b0, cfg.act};
	assign fe_line = last_act + {9'h000, cfg.vfp} + 17'h00001;
	assign idx_w = {1'b0, st_r.line_idx};
	assign pd_end = (cfg.pd == 16'h0000) ? 16'h0000 : cfg.pd - 16'h0001;
	assign acc_sum = st_r.ns_acc + `PTG_CLK_NS;
	assign tick_10ns = (acc_sum >= `PTG_UNIT_NS);

	////////////////////////////////////////////////////////////////////////////////
	// Line classification
	assign line_go = st_r.line_pend && (st_r.line_idx != 16'h0000 || cfg.enable);
	assign is_start = (st_r.line_idx == 16'h0000);
	assign is_active = (idx_w >= first_act) && (idx_w <= last_act);
	assign is_end = (idx_w == fe_line);
	assign is_wrap = (idx_w + 17'h00001 >= {1'b0, cfg.tot}) && (idx_w >= fe_line);

	always_comb begin
		hdr_go = 1'b0;
		hdr_short_sel = 1'b1;
		hdr_dt_sel = `PTG_DT_FS;
		hdr_wc_sel = 16'h0000;
		if (is_start) begin
			hdr_go = 1'b1;
		end else if (is_active) begin
			hdr_go = 1'b1;
			hdr_short_sel = 1'b0;
			hdr_dt_sel = cfg.dt;
			hdr_wc_sel = cfg.line_len;
		end else if (is_end) begin
			hdr_go = 1'b1;
			hdr_dt_sel = `PTG_DT_FE;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Byte stepping
	assign last_take = (st_r.byte_cnt == st_r.hdr_wc - 16'h0001);
	assign bar_step = (st_r.bar_cnt + 16'h0001 >= cfg.bar_len) && (st_r.bar_idx != last_bar);
	assign bar_idx_nxt = bar_step ? st_r.bar_idx + 3'h1 : st_r.bar_idx;
	assign bar_cnt_nxt = bar_step ? 16'h0000 : st_r.bar_cnt + 16'h0001;

	always_comb begin
		if (bar_step || st_r.blk_idx == last_blk) begin
			blk_idx_nxt = 4'h0;
		end else begin
			blk_idx_nxt = st_r.blk_idx + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_comb begin
		st_nxt = st_r;

		case (st_r.state)
			ptg_pkg::PTG_IDLE: begin
				if (line_go) begin
					st_nxt.line_pend = 1'b0;
					st_nxt.in_active = hdr_go && !hdr_short_sel;
					if (hdr_go) begin
						st_nxt.state = ptg_pkg::PTG_HDR;
						st_nxt.hdr_short = hdr_short_sel;
						st_nxt.hdr_dt = hdr_dt_sel;
						st_nxt.hdr_wc = hdr_wc_sel;
					end
					if (is_start) begin
						st_nxt.frame_on = 1'b1;
					end else if (is_end) begin
						st_nxt.frame_on = 1'b0;
					end
					if (is_wrap) begin
						st_nxt.line_idx = 16'h0000;
					end else begin
						st_nxt.line_idx = st_r.line_idx + 16'h0001;
					end
				end else if (st_r.line_pend) begin
					// Halted at line zero: a stale tick would start the next frame off period
					st_nxt.line_pend = 1'b0;
				end
			end
			ptg_pkg::PTG_HDR: begin
				if (hdr_ready_in) begin
					st_nxt.byte_cnt = 16'h0000;
					st_nxt.bar_cnt = 16'h0000;
					st_nxt.bar_idx = 3'h0;
					st_nxt.blk_idx = 4'h0;
					st_nxt.byte_r = ptg_pattern(cfg.fixed_mode, 3'h0, 4'h0, cfg.fix);
					if (st_r.hdr_short || st_r.hdr_wc == 16'h0000) begin
						st_nxt.state = ptg_pkg::PTG_IDLE;
					end else begin
						st_nxt.state = ptg_pkg::PTG_DATA;
					end
				end
			end
			ptg_pkg::PTG_DATA: begin
				if (data_ready_in) begin
					if (last_take) begin
						st_nxt.state = ptg_pkg::PTG_IDLE;
					end else begin
						st_nxt.byte_cnt = st_r.byte_cnt + 16'h0001;
						st_nxt.bar_idx = bar_idx_nxt;
						st_nxt.bar_cnt = bar_cnt_nxt;
						st_nxt.blk_idx = blk_idx_nxt;
						st_nxt.byte_r = ptg_pattern(cfg.fixed_mode, bar_idx_nxt,
							blk_idx_nxt, cfg.fix);
					end
				end
			end
			default: begin
				st_nxt.state = ptg_pkg::PTG_IDLE;
			end
		endcase

		// line period timer
		// Last in the process so a tick in a consuming cycle is kept
		st_nxt.ns_acc = tick_10ns ? acc_sum - `PTG_UNIT_NS : acc_sum;
		if (tick_10ns) begin
			if (st_r.pd_cnt >= pd_end) begin
				st_nxt.pd_cnt = 16'h0000;
				st_nxt.line_pend = 1'b1;
			end else begin
				st_nxt.pd_cnt = st_r.pd_cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge clock_in or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			st_r <= '0;
			st_r.state <= ptg_pkg::PTG_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign hdr_valid_out = (st_r.state == ptg_pkg::PTG_HDR);
	assign hdr_short_out = st_r.hdr_short;
	assign hdr_dt_out = st_r.hdr_dt;
	assign hdr_vc_out = cfg.vc;
	assign hdr_wc_out = st_r.hdr_wc;
	assign data_valid_out = (st_r.state == ptg_pkg::PTG_DATA);
	assign data_byte_out = st_r.byte_r;
	assign data_last_out = data_valid_out && last_take;
	assign cfg.status = {st_r.frame_on, st_r.in_active, 4'h0, st_r.state};

endmodule

// ==== ptg_top_properties.sv ====
// Port-level checker of the pattern generator
`timescale 1ns/1ps
`include "ptg_defs.svh"
module ptg_top_properties (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic reg_read_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic hdr_valid_out,
	input wire logic hdr_ready_in,
	input wire logic hdr_short_out,
	input wire logic [5:0] hdr_dt_out,
	input wire logic [1:0] hdr_vc_out,
	input wire logic [15:0] hdr_wc_out,
	input wire logic data_valid_out,
	input wire logic data_ready_in,
	input wire logic [7:0] data_byte_out,
	input wire logic data_last_out
);
	logic [15:0] bcnt_r;
	logic [15:0] wc_r;
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_n_in);
	////////////////////////////////////////////////////////////////
	// Bytes taken since the last header
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bcnt_r <= 16'h0000;
			wc_r <= 16'h0000;
		end else if (hdr_valid_out && hdr_ready_in) begin
			bcnt_r <= 16'h0000;
			wc_r <= hdr_wc_out;
		end else if (data_valid_out && data_ready_in) begin
			bcnt_r <= bcnt_r + 16'h0001;
		end
	end
	////////////////////////////////////////////////////////////////
	a_hdr_held: assert property (hdr_valid_out && !hdr_ready_in |=> hdr_valid_out &&
		$stable({hdr_short_out, hdr_dt_out, hdr_vc_out, hdr_wc_out}))
		else $error("header changed before acceptance");
	a_byte_held: assert property (data_valid_out && !data_ready_in |=> data_valid_out &&
		$stable({data_byte_out, data_last_out}))
		else $error("payload byte changed before acceptance");
	a_short_fields: assert property (hdr_valid_out && hdr_short_out |-> hdr_wc_out == 16'h0000 &&
		(hdr_dt_out == `PTG_DT_FS || hdr_dt_out == `PTG_DT_FE))
		else $error("short packet with bad fields");
	a_one_offer: assert property (!(hdr_valid_out && data_valid_out))
		else $error("header and byte offered together");
	a_payload_next: assert property (hdr_valid_out && hdr_ready_in && !hdr_short_out &&
		hdr_wc_out != 16'h0000 |=> data_valid_out)
		else $error("payload did not follow long header");
	a_line_close: assert property (data_valid_out && data_ready_in && data_last_out
		|=> !data_valid_out)
		else $error("bytes offered after last byte");
	a_last_count: assert property (data_valid_out |->
		data_last_out == (bcnt_r == wc_r - 16'h0001))
		else $error("last byte flag does not match word count");
	a_rdata_hold: assert property (!reg_read_in |=> $stable(reg_rdata_out))
		else $error("read data changed without read");
endmodule
bind ptg_top ptg_top_properties ptg_top_properties_i (.clock_in(clock_in), .rst_n_in(rst_n_in),
	.reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out), .hdr_valid_out(hdr_valid_out),
	.hdr_ready_in(hdr_ready_in), .hdr_short_out(hdr_short_out), .hdr_dt_out(hdr_dt_out),
	.hdr_vc_out(hdr_vc_out), .hdr_wc_out(hdr_wc_out), .data_valid_out(data_valid_out),
	.data_ready_in(data_ready_in), .data_byte_out(data_byte_out), .data_last_out(data_last_out));

// ==== ptg_sink.sv ====
// Transmitter model that takes packet headers and payload bytes
`timescale 1ns/1ps
module ptg_sink (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic slow_in,
	output logic hdr_ready_out,
	output logic data_ready_out
);
	logic ph = 1'b0;
	initial begin
		hdr_ready_out = 1'b0;
		data_ready_out = 1'b0;
	end
	// takes formatted packets
	// Slow mode accepts on alternate cycles only
	always @(posedge clock_in) begin
		#1;
		ph = ~ph;
		hdr_ready_out = rst_n_in && (!slow_in || ph);
		data_ready_out = rst_n_in && (!slow_in || !ph);
	end
endmodule

// ==== tb.sv ====
// Self-checking bench of the pattern generator
`timescale 1ns/1ps
`include "ptg_defs.svh"
module tb;
	localparam int PD = 20;
	localparam int LC = PD * 10 / 4;
	logic clock_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [7:0] reg_addr_in = 8'h00;
	logic [7:0] reg_wdata_in = 8'h00;
	logic reg_write_in = 1'b0;
	logic reg_read_in = 1'b0;
	logic slow = 1'b0;
	logic [7:0] reg_rdata_out;
	logic hdr_valid_out, hdr_ready_in, hdr_short_out, data_valid_out, data_ready_in, data_last_out;
	logic [5:0] hdr_dt_out;
	logic [1:0] hdr_vc_out;
	logic [15:0] hdr_wc_out;
	logic [7:0] data_byte_out;
	int fail_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	int t_last = 0;
	logic [7:0] bar_col [8] = '{`PTG_BAR_C0, `PTG_BAR_C1, `PTG_BAR_C2, `PTG_BAR_C3,
		`PTG_BAR_C4, `PTG_BAR_C5, `PTG_BAR_C6, `PTG_BAR_C7};
	logic [7:0] c_cfg [5] = '{8'h33, 8'h10, 8'h00, 8'ha3, 8'h80};
	logic [7:0] c_di [5] = '{8'h24, 8'h6b, 8'hd2, 8'h2a, 8'h9e};
	logic [15:0] c_line [5] = '{16'h0014, 16'h0009, 16'h0005, 16'h0010, 16'h0014};
	logic [15:0] c_bar [5] = '{16'h0002, 16'h0004, 16'h0002, 16'h0003, 16'h0014};

	ptg_top ptg_top_i (.clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
		.reg_rdata_out(reg_rdata_out), .hdr_valid_out(hdr_valid_out), .hdr_ready_in(hdr_ready_in),
		.hdr_short_out(hdr_short_out), .hdr_dt_out(hdr_dt_out), .hdr_vc_out(hdr_vc_out),
		.hdr_wc_out(hdr_wc_out), .data_valid_out(data_valid_out), .data_ready_in(data_ready_in),
		.data_byte_out(data_byte_out), .data_last_out(data_last_out));
	ptg_sink ptg_sink_i (.clock_in(clock_in), .rst_n_in(rst_n_in), .slow_in(slow),
		.hdr_ready_out(hdr_ready_in), .data_ready_out(data_ready_in));

	always #2 clock_in = ~clock_in;
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 30000) begin
			fail_count++;
			test_done();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("mismatches %0d comparisons %0d", fail_count, samples_checked);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_in);
		#1;
		reg_addr_in = a;
		reg_wdata_in = d;
		reg_write_in = 1'b1;
		@(posedge clock_in);
		#1;
		reg_write_in = 1'b0;
	endtask
	task automatic wr16(input logic [7:0] a, input logic [15:0] v);
		reg_wr(a, v[15:8]);
		reg_wr(a + 8'h01, v[7:0]);
	endtask
	task automatic reg_rd(input logic [7:0] a, input logic [7:0] e, input string n);
		@(posedge clock_in);
		#1;
		reg_addr_in = a;
		reg_read_in = 1'b1;
		@(posedge clock_in);
		#1;
		reg_read_in = 1'b0;
		chk(n, {8'h00, e}, {8'h00, reg_rdata_out});
	endtask
	// Waits at the falling edge for a handshake that the next rising edge takes
	task automatic wait_acc(input bit hdr);
		int n;
		n = 0;
		do begin
			@(negedge clock_in);
			n++;
		end while ((hdr ? hdr_valid_out & hdr_ready_in : data_valid_out & data_ready_in) !== 1'b1
			&& n < 2000);
		chk("handshake", 16'h0001, {15'h0000, n < 2000});
	endtask
	task automatic wait_hdr(input logic sh, input logic [5:0] dt, input logic [15:0] wc,
		input logic [1:0] vc, input int gap);
		wait_acc(1'b1);
		chk("hdr_short", {15'h0000, sh}, {15'h0000, hdr_short_out});
		chk("hdr_dt", {10'h000, dt}, {10'h000, hdr_dt_out});
		chk("hdr_wc", wc, hdr_wc_out);
		chk("hdr_vc", {14'h0000, vc}, {14'h0000, hdr_vc_out});
		@(posedge clock_in);
		if (gap > 0) chk("line_gap", 16'h0001, {15'h0000, (cyc - t_last) inside {[gap - 3:gap + 3]}});
		t_last = cyc;
	endtask
	function automatic logic [7:0] fixv(input logic [3:0] p);
		return {p, ~p};
	endfunction
	function automatic logic [7:0] exp_byte(input int k, input int i);
		int n;
		int b;
		int blk;
		n = 1 << c_cfg[k][5:4];
		b = i / c_bar[k];
		if (b > n - 1) b = n - 1;
		if (c_cfg[k][7]) begin
			blk = (c_cfg[k][3:0] == 4'h0) ? 16 : c_cfg[k][3:0];
			return fixv(4'((i - b * c_bar[k]) % blk)) ^ (b[0] ? 8'hff : 8'h00);
		end
		return bar_col[b];
	endfunction
	task automatic run_frame(input int k, input bit again);
		logic [1:0] vc;
		vc = c_di[k][7:6];
		wait_hdr(1'b1, `PTG_DT_FS, 16'h0000, vc, again ? 2 * LC : 0);
		if (again) reg_wr(`PTG_OFF_CTL, 8'h00);
		else reg_rd(`PTG_OFF_STATUS, 8'h80, "status_frame");
		wait_hdr(1'b0, c_di[k][5:0], c_line[k], vc, 2 * LC);
		for (int i = 0; i < c_line[k]; i++) begin
			wait_acc(1'b0);
			chk("data_byte", {8'h00, exp_byte(k, i)}, {8'h00, data_byte_out});
			chk("data_last", {15'h0000, i == c_line[k] - 1}, {15'h0000, data_last_out});
			@(posedge clock_in);
		end
		wait_hdr(1'b1, `PTG_DT_FE, 16'h0000, vc, 2 * LC);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		logic stray;
		repeat (16) @(posedge clock_in);
		#1;
		rst_n_in = 1'b1;
		repeat (4) @(posedge clock_in);
		reg_rd(`PTG_OFF_CTL, `PTG_RST_CTL, "ctl_reset");
		reg_rd(`PTG_OFF_CFG, `PTG_RST_CFG, "cfg_reset");
		reg_rd(`PTG_OFF_DI, `PTG_RST_DI, "di_reset");
		reg_rd(`PTG_OFF_FIX15, `PTG_RST_BYTE, "fix_reset");
		reg_wr(`PTG_OFF_STATUS, 8'hff);
		reg_rd(`PTG_OFF_STATUS, 8'h00, "status_ro");
		reg_wr(8'h30, 8'h5a);
		reg_rd(8'h30, 8'h00, "unmapped");
		wr16(`PTG_OFF_ACT1, 16'h0001);
		wr16(`PTG_OFF_TOT1, 16'h0006);
		wr16(`PTG_OFF_PD1, 16'(PD));
		reg_wr(`PTG_OFF_VBP, 8'h01);
		reg_wr(`PTG_OFF_VFP, 8'h01);
		for (int p = 0; p < 16; p++) reg_wr(`PTG_OFF_FIX0 + 8'(p), fixv(4'(p)));
		reg_rd(`PTG_OFF_FIX0 + 8'h05, fixv(4'h5), "fix_readback");
		for (int k = 0; k < 5; k++) begin
			slow = (k == 3);
			reg_wr(`PTG_OFF_CFG, c_cfg[k]);
			reg_wr(`PTG_OFF_DI, c_di[k]);
			wr16(`PTG_OFF_LINE1, c_line[k]);
			wr16(`PTG_OFF_BAR1, c_bar[k]);
			reg_wr(`PTG_OFF_CTL, 8'h01);
			run_frame(k, 1'b0);
			run_frame(k, 1'b1);
			stray = 1'b0;
			repeat (3 * LC) begin
				@(negedge clock_in);
				if (hdr_valid_out !== 1'b0) stray = 1'b1;
			end
			chk("halted", 16'h0000, {15'h0000, stray});
		end
		test_done();
	end
endmodule
